//--- core/ssr_map.vh
// address map, field positions and reset values of the status reporting block
`ifndef SSR_MAP_VH
`define SSR_MAP_VH

// group selectors on the command port
`define SSR_GRP_W 3
`define SSR_GRP_DEVICE 3'h0
`define SSR_GRP_QUEST 3'h1
`define SSR_GRP_OPER 3'h2
`define SSR_GRP_STD 3'h3
`define SSR_GRP_TOP 3'h4

// part selectors on the command port
`define SSR_PART_W 3
`define SSR_PART_LIVE 3'h0
`define SSR_PART_RISE 3'h1
`define SSR_PART_FALL 3'h2
`define SSR_PART_FLAGS 3'h3
`define SSR_PART_MASK 3'h4

// top group: live part is the status byte, mask part the service request mask
`define SSR_TOP_LIVE `SSR_PART_LIVE
`define SSR_TOP_MASK `SSR_PART_MASK

// status byte bit positions
`define SSR_STB_UNUSED 0
`define SSR_STB_DEVICE 1
`define SSR_STB_ERRQ 2
`define SSR_STB_QUEST 3
`define SSR_STB_MSG 4
`define SSR_STB_STD 5
`define SSR_STB_SUMMARY 6
`define SSR_STB_OPER 7

// group part width and the always-zero top bit
`define SSR_PART_BITS 16
`define SSR_PART_TOPBIT 15
`define SSR_PART_LIVE_MASK 16'h7FFF

// reset values
`define SSR_RISE_RST 16'h7FFF
`define SSR_FALL_RST 16'h0000
`define SSR_MASK_RST 16'h0000
`define SSR_STD_MASK_RST 8'h00
`define SSR_SRM_RST 8'h00

`endif

//--- core/ssr_status_reporting.v
// hierarchical status reporting: register groups, status byte and service request
`timescale 1ns/100ps
`include "ssr_map.vh"

// Function
// R01: every group has five 16-bit parts; one status keeps one bit position. The standard and top groups here have only two 8-bit parts.
// R02: bit 15 of every part of every group always reads zero.
// R03: live part follows hardware or lower sum; read-only, unaffected by reads.
// R04: live bit rising sets its flag when the rise filter bit is one.
// R05: live bit falling sets its flag when the fall filter bit is one.
// R06: rise and fall filters are writable and readable; reads leave them alone.
// R07: flags keep every filtered event until the flags part is read.
// R08: flags part is read-only; a read returns contents then clears all.
// R09: sum bit is OR of flags ANDed with mask; zero mask bit excludes.
// R10: mask part is writable and readable; reads leave it unchanged.
// R11: each group sum feeds an assigned live bit of the next higher level.
// R12: status byte bit 6 summarises the other status byte bits.
// R13: status byte readable by query or serial poll, returning current value.
// R14: service request mask has one bit per status bit; bit 6 ignored.
// R15: enabled status byte bit going 0 to 1 raises a service request.
// R16: service request mask is written and read back by commands.
// R17: status bit 0 unused; bit 1 carries the device group sum.
// R18: status bit 2 is set while the error queue holds an entry.
// R19: with bit 2 enabled, every new error entry raises a service request.
// R20: status bit 3 is the questionable group sum.
// R21: status bit 4 is set while an output message waits.
// R22: status bit 5 is the standard flags summary.
// R23: status bit 6 set when any other enabled status bit is set.
// R24: status bit 7 is the operation group sum.
// R25: a flag set in the same cycle as its clearing read is kept.
module ssr_status_reporting (
  // clock, reset, enable
  input wire CORE_CLK_I,
  input wire NRST_I,
  input wire CE_I,
  // hardware status
  input wire [15:0] DEV_STATUS_I,
  input wire [15:0] QUEST_STATUS_I,
  input wire [15:0] OPER_STATUS_I,
  input wire [7:0] STD_EVENT_I,
  input wire ERRQ_NOT_EMPTY_I,
  input wire ERRQ_NEW_ENTRY_I,
  input wire OUTPUT_MESSAGE_WAITING_I,
  // command port
  input wire CMD_VALID_I,
  input wire CMD_WRITE_I,
  input wire [2:0] CMD_GROUP_I,
  input wire [2:0] CMD_PART_I,
  input wire [15:0] CMD_WDATA_I,
  input wire SERIAL_POLL_I,
  // answers
  output reg RSP_VALID_O,
  output reg [15:0] RSP_DATA_O,
  output reg [7:0] TOP_STATUS_BYTE_O,
  output reg SERVICE_REQUEST_O
);
  reg [7:0] standard_flags_group;
  reg [7:0] standard_flags_mask;
  reg [7:0] service_request_mask;
  reg [7:0] prev_req;
  wire cmd_rd;
  wire cmd_wr;
  // group and part decode shared by every strobe
  wire sel_dev;
  wire sel_qst;
  wire sel_opr;
  wire sel_std;
  wire sel_top;
  wire part_rise;
  wire part_fall;
  wire part_flags;
  wire part_mask;
  wire dev_wr_rise;
  wire dev_wr_fall;
  wire dev_wr_mask;
  wire dev_rd_flags;
  wire qst_wr_rise;
  wire qst_wr_fall;
  wire qst_wr_mask;
  wire qst_rd_flags;
  wire opr_wr_rise;
  wire opr_wr_fall;
  wire opr_wr_mask;
  wire opr_rd_flags;
  wire std_wr_mask;
  wire top_wr_mask;
  wire [15:0] dev_live;
  wire [15:0] dev_rise;
  wire [15:0] dev_fall;
  wire [15:0] dev_flags;
  wire [15:0] dev_mask;
  wire [15:0] qst_live;
  wire [15:0] qst_rise;
  wire [15:0] qst_fall;
  wire [15:0] qst_flags;
  wire [15:0] qst_mask;
  wire [15:0] opr_live;
  wire [15:0] opr_rise;
  wire [15:0] opr_fall;
  wire [15:0] opr_flags;
  wire [15:0] opr_mask;
  // sums of the three lower groups
  wire dev_sum;
  wire qst_sum;
  wire opr_sum;
  wire standard_flags_summary;
  wire std_rd;
  wire [7:0] next_std;
  wire [7:0] others;
  wire service_pending_summary;
  wire [7:0] next_stb;
  wire [7:0] req;
  wire raise;
  // answer path
  reg [15:0] rd_mux;

  assign cmd_rd = CMD_VALID_I & ~CMD_WRITE_I;
  assign cmd_wr = CMD_VALID_I & CMD_WRITE_I;
  assign sel_dev = CMD_GROUP_I == `SSR_GRP_DEVICE;
  assign sel_qst = CMD_GROUP_I == `SSR_GRP_QUEST;
  assign sel_opr = CMD_GROUP_I == `SSR_GRP_OPER;
  assign sel_std = CMD_GROUP_I == `SSR_GRP_STD;
  assign sel_top = CMD_GROUP_I == `SSR_GRP_TOP;
  assign part_rise = CMD_PART_I == `SSR_PART_RISE;
  assign part_fall = CMD_PART_I == `SSR_PART_FALL;
  assign part_flags = CMD_PART_I == `SSR_PART_FLAGS;
  assign part_mask = CMD_PART_I == `SSR_PART_MASK;
  // live and flag parts get no write strobe, so writes to them fall away
  assign dev_wr_rise = cmd_wr & sel_dev & part_rise;
  assign dev_wr_fall = cmd_wr & sel_dev & part_fall;
  assign dev_wr_mask = cmd_wr & sel_dev & part_mask;
  assign dev_rd_flags = cmd_rd & sel_dev & part_flags;
  assign qst_wr_rise = cmd_wr & sel_qst & part_rise;
  assign qst_wr_fall = cmd_wr & sel_qst & part_fall;
  assign qst_wr_mask = cmd_wr & sel_qst & part_mask;
  assign qst_rd_flags = cmd_rd & sel_qst & part_flags;
  assign opr_wr_rise = cmd_wr & sel_opr & part_rise;
  assign opr_wr_fall = cmd_wr & sel_opr & part_fall;
  assign opr_wr_mask = cmd_wr & sel_opr & part_mask;
  assign opr_rd_flags = cmd_rd & sel_opr & part_flags;
  assign std_wr_mask = cmd_wr & sel_std & part_mask;
  assign top_wr_mask = cmd_wr & sel_top & part_mask;

  ssr_group #(
    .WIDTH(`SSR_PART_BITS),
    .RISE_RST(`SSR_RISE_RST)
  ) u_dev (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .hw_i(DEV_STATUS_I),
    .wr_rise_i(dev_wr_rise),
    .wr_fall_i(dev_wr_fall),
    .wr_mask_i(dev_wr_mask),
    .rd_flags_i(dev_rd_flags),
    .wdata_i(CMD_WDATA_I),
    .live_o(dev_live),
    .rise_o(dev_rise),
    .fall_o(dev_fall),
    .flags_o(dev_flags),
    .mask_o(dev_mask),
    .sum_o(dev_sum)
  );

  ssr_group #(
    .WIDTH(`SSR_PART_BITS),
    .RISE_RST(`SSR_RISE_RST)
  ) u_qst (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .hw_i(QUEST_STATUS_I),
    .wr_rise_i(qst_wr_rise),
    .wr_fall_i(qst_wr_fall),
    .wr_mask_i(qst_wr_mask),
    .rd_flags_i(qst_rd_flags),
    .wdata_i(CMD_WDATA_I),
    .live_o(qst_live),
    .rise_o(qst_rise),
    .fall_o(qst_fall),
    .flags_o(qst_flags),
    .mask_o(qst_mask),
    .sum_o(qst_sum)
  );

  ssr_group #(
    .WIDTH(`SSR_PART_BITS),
    .RISE_RST(`SSR_RISE_RST)
  ) u_opr (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .hw_i(OPER_STATUS_I),
    .wr_rise_i(opr_wr_rise),
    .wr_fall_i(opr_wr_fall),
    .wr_mask_i(opr_wr_mask),
    .rd_flags_i(opr_rd_flags),
    .wdata_i(CMD_WDATA_I),
    .live_o(opr_live),
    .rise_o(opr_rise),
    .fall_o(opr_fall),
    .flags_o(opr_flags),
    .mask_o(opr_mask),
    .sum_o(opr_sum)
  );

  // standard flags: event pulses latch directly, read clears, set wins
  assign std_rd = cmd_rd & sel_std & part_flags;
  assign next_std = (std_rd ? 8'h00 : standard_flags_group) | STD_EVENT_I; // R25
  assign standard_flags_summary = |(standard_flags_group & standard_flags_mask); // R22

  // status byte assembly; sums of lower groups feed it directly
  assign others[`SSR_STB_UNUSED] = 1'b0; // R17
  assign others[`SSR_STB_DEVICE] = dev_sum; // R11 R17
  assign others[`SSR_STB_ERRQ] = ERRQ_NOT_EMPTY_I; // R18
  assign others[`SSR_STB_QUEST] = qst_sum; // R20
  assign others[`SSR_STB_MSG] = OUTPUT_MESSAGE_WAITING_I; // R21
  assign others[`SSR_STB_STD] = standard_flags_summary; // R22
  assign others[`SSR_STB_SUMMARY] = 1'b0;
  assign others[`SSR_STB_OPER] = opr_sum; // R24
  // mask bit 6 never takes part
  assign req = others & service_request_mask & 8'hBF; // R14
  assign service_pending_summary = |req; // R12 R23
  assign next_stb = others | {1'b0, service_pending_summary, 6'h00}; // R12 R23

  // request on an enabled 0-to-1 edge, or on each new error entry while enabled
  assign raise = (|(req & ~prev_req)) |
                 (ERRQ_NEW_ENTRY_I & service_request_mask[`SSR_STB_ERRQ]); // R15 R19

  always @* begin
    rd_mux = 16'h0000;
    case (CMD_GROUP_I)
      `SSR_GRP_DEVICE: begin
        case (CMD_PART_I)
          `SSR_PART_LIVE: rd_mux = dev_live;
          `SSR_PART_RISE: rd_mux = dev_rise;
          `SSR_PART_FALL: rd_mux = dev_fall;
          `SSR_PART_FLAGS: rd_mux = dev_flags;
          `SSR_PART_MASK: rd_mux = dev_mask;
          default: rd_mux = 16'h0000;
        endcase
      end
      `SSR_GRP_QUEST: begin
        case (CMD_PART_I)
          `SSR_PART_LIVE: rd_mux = qst_live;
          `SSR_PART_RISE: rd_mux = qst_rise;
          `SSR_PART_FALL: rd_mux = qst_fall;
          `SSR_PART_FLAGS: rd_mux = qst_flags;
          `SSR_PART_MASK: rd_mux = qst_mask;
          default: rd_mux = 16'h0000;
        endcase
      end
      `SSR_GRP_OPER: begin
        case (CMD_PART_I)
          `SSR_PART_LIVE: rd_mux = opr_live;
          `SSR_PART_RISE: rd_mux = opr_rise;
          `SSR_PART_FALL: rd_mux = opr_fall;
          `SSR_PART_FLAGS: rd_mux = opr_flags;
          `SSR_PART_MASK: rd_mux = opr_mask;
          default: rd_mux = 16'h0000;
        endcase
      end
      `SSR_GRP_STD: begin
        case (CMD_PART_I)
          `SSR_PART_FLAGS: rd_mux = {8'h00, standard_flags_group}; // R08
          `SSR_PART_MASK: rd_mux = {8'h00, standard_flags_mask};
          default: rd_mux = 16'h0000;
        endcase
      end
      `SSR_GRP_TOP: begin
        case (CMD_PART_I)
          `SSR_TOP_LIVE: rd_mux = {8'h00, TOP_STATUS_BYTE_O}; // R13
          `SSR_TOP_MASK: rd_mux = {8'h00, service_request_mask}; // R16
          default: rd_mux = 16'h0000;
        endcase
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      standard_flags_group <= 8'h00;
      standard_flags_mask <= `SSR_STD_MASK_RST;
      service_request_mask <= `SSR_SRM_RST;
      prev_req <= 8'h00;
      TOP_STATUS_BYTE_O <= 8'h00;
      SERVICE_REQUEST_O <= 1'b0;
      RSP_VALID_O <= 1'b0;
      RSP_DATA_O <= 16'h0000;
    end else if (CE_I) begin
      standard_flags_group <= next_std;
      prev_req <= req;
      TOP_STATUS_BYTE_O <= next_stb;
      if (std_wr_mask) begin
        standard_flags_mask <= CMD_WDATA_I[7:0];
      end
      if (top_wr_mask) begin
        service_request_mask <= CMD_WDATA_I[7:0]; // R16
      end
      // a serial poll acknowledges the request; a fresh edge raises it again
      if (raise) begin
        SERVICE_REQUEST_O <= 1'b1; // R15 R19
      end else if (SERIAL_POLL_I || !service_pending_summary) begin
        SERVICE_REQUEST_O <= 1'b0;
      end
      RSP_VALID_O <= cmd_rd | SERIAL_POLL_I;
      if (SERIAL_POLL_I) begin
        RSP_DATA_O <= {8'h00, TOP_STATUS_BYTE_O}; // R13
      end else if (cmd_rd) begin
        RSP_DATA_O <= rd_mux; // R06 R10
      end
    end
  end
endmodule // ssr_status_reporting

// one five-part status group
module ssr_group #(
  parameter WIDTH = 16,
  parameter [15:0] RISE_RST = 16'h7FFF
) (
  // clock, reset, enable
  input wire clk_i,
  input wire nrst_i,
  input wire ce_i,
  // hardware status and command strobes
  input wire [WIDTH-1:0] hw_i,
  input wire wr_rise_i,
  input wire wr_fall_i,
  input wire wr_mask_i,
  input wire rd_flags_i,
  input wire [WIDTH-1:0] wdata_i,
  // parts and sum bit
  output reg [WIDTH-1:0] live_o,
  output reg [WIDTH-1:0] rise_o,
  output reg [WIDTH-1:0] fall_o,
  output reg [WIDTH-1:0] flags_o,
  output reg [WIDTH-1:0] mask_o,
  output wire sum_o
);
  wire [WIDTH-1:0] keep_low;
  wire [WIDTH-1:0] next_live;
  wire [WIDTH-1:0] hit;
  wire [WIDTH-1:0] next_flags;

  // top bit held at zero so controllers never see a negative value
  assign keep_low = {1'b0, {(WIDTH-1){1'b1}}}; // R02
  assign next_live = hw_i & keep_low; // R01 R03
  assign hit = (next_live & ~live_o & rise_o) | (~next_live & live_o & fall_o); // R04 R05
  // a new hit survives a read in the same cycle
  assign next_flags = ((rd_flags_i ? {WIDTH{1'b0}} : flags_o) | hit) & keep_low; // R07 R08 R25
  assign sum_o = |(flags_o & mask_o); // R09

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      live_o <= {WIDTH{1'b0}};
      rise_o <= RISE_RST[WIDTH-1:0] & {1'b0, {(WIDTH-1){1'b1}}};
      fall_o <= {WIDTH{1'b0}};
      flags_o <= {WIDTH{1'b0}};
      mask_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      live_o <= next_live; // R03
      flags_o <= next_flags; // R07
      if (wr_rise_i) begin
        rise_o <= wdata_i & keep_low; // R06
      end
      if (wr_fall_i) begin
        fall_o <= wdata_i & keep_low; // R06
      end
      if (wr_mask_i) begin
        mask_o <= wdata_i & keep_low; // R10
      end
    end
  end
endmodule // ssr_group

//--- testbench/ssr_status_chk.sv
// port-level assertions for the status reporting block
`timescale 1ns/100ps
module ssr_chk (
  // clock, reset, enable
  input wire CORE_CLK_I,
  input wire NRST_I,
  input wire CE_I,
  // status and command inputs
  input wire ERRQ_NOT_EMPTY_I,
  input wire CMD_VALID_I,
  input wire CMD_WRITE_I,
  input wire [2:0] CMD_GROUP_I,
  input wire SERIAL_POLL_I,
  // answers
  input wire RSP_VALID_O,
  input wire [15:0] RSP_DATA_O,
  input wire [7:0] TOP_STATUS_BYTE_O,
  input wire SERVICE_REQUEST_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_query;
    CE_I && CMD_VALID_I && !CMD_WRITE_I && !SERIAL_POLL_I;
  endsequence
  // poll only judged while the byte is quiet
  sequence s_poll;
    CE_I && SERIAL_POLL_I && $stable(TOP_STATUS_BYTE_O);
  endsequence
  a_msb_zero: assert property (RSP_VALID_O |-> !RSP_DATA_O[15])
    else $error("answer bit 15 set");
  a_bit0_unused: assert property (!TOP_STATUS_BYTE_O[0])
    else $error("status bit 0 set");
  a_errq_bit: assert property ((CE_I && ERRQ_NOT_EMPTY_I)[*2] |=> TOP_STATUS_BYTE_O[2])
    else $error("error queue bit missing");
  a_query_answer: assert property (s_query |=> RSP_VALID_O)
    else $error("query not answered");
  a_unmapped_zero: assert property ((s_query ##0 CMD_GROUP_I > 3'h4) |=> RSP_DATA_O == 16'h0000)
    else $error("unmapped query not zero");
  a_poll_byte: assert property (s_poll |=> (!$stable(TOP_STATUS_BYTE_O) ||
    (RSP_VALID_O && RSP_DATA_O == {8'h00, TOP_STATUS_BYTE_O})))
    else $error("poll answer wrong");
  a_srq_rise: assert property ($rose(SERVICE_REQUEST_O) |-> TOP_STATUS_BYTE_O[6])
    else $error("request without summary");
  a_summary_cause: assert property (TOP_STATUS_BYTE_O[6] |-> (TOP_STATUS_BYTE_O & 8'hBF) != 8'h00)
    else $error("summary without cause");
endmodule // ssr_chk

bind ssr_status_reporting ssr_chk ssr_chk_inst (.CORE_CLK_I, .NRST_I, .CE_I, .ERRQ_NOT_EMPTY_I,
  .CMD_VALID_I, .CMD_WRITE_I, .CMD_GROUP_I, .SERIAL_POLL_I, .RSP_VALID_O, .RSP_DATA_O,
  .TOP_STATUS_BYTE_O, .SERVICE_REQUEST_O);

//--- testbench/ssr_ctrl_model.sv
// bus controller model: serial-polls after each service request
`timescale 1ns/100ps
module ssr_ctrl_model (
  // clock and control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [3:0] lag_i,
  // request in, poll out
  input wire logic srq_i,
  output wire logic poll_o,
  output wire logic [7:0] polls_o
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] gap = 2'h0;
  logic poll = 1'b0;
  logic [7:0] polls = 8'h00;
  assign poll_o = poll;
  assign polls_o = polls;
  // gap lets the request fall before it is looked at again
  always @(posedge clk_i) begin
    if (poll) begin
      poll <= #1 1'b0;
      gap <= #1 2'h3;
    end else if (gap != 2'h0) begin
      gap <= #1 gap - 2'h1;
    end else if (en_i && srq_i) begin
      cnt <= #1 (cnt == lag_i) ? 4'h0 : cnt + 4'h1;
      poll <= #1 (cnt == lag_i);
      polls <= #1 polls + {7'h00, cnt == lag_i};
    end else begin
      cnt <= #1 4'h0;
    end
  end
endmodule // ssr_ctrl_model

//--- testbench/tb_top.sv
// self-checking bench for the status reporting block
`timescale 1ns/100ps
module tb_top;
  logic CORE_CLK_I, NRST_I, CE_I, ERRQ_NOT_EMPTY_I, ERRQ_NEW_ENTRY_I, OUTPUT_MESSAGE_WAITING_I;
  logic [15:0] DEV_STATUS_I, QUEST_STATUS_I, OPER_STATUS_I, CMD_WDATA_I, RSP_DATA_O, rsp;
  logic [7:0] STD_EVENT_I, TOP_STATUS_BYTE_O, polls, sb;
  logic [2:0] CMD_GROUP_I, CMD_PART_I;
  logic CMD_VALID_I, CMD_WRITE_I, SERIAL_POLL_I, RSP_VALID_O, SERVICE_REQUEST_O, vld, en;
  logic [3:0] lag;
  int error_cnt = 0;
  int num_checks = 0;
  ssr_status_reporting ssr_status_reporting_inst (.CORE_CLK_I, .NRST_I, .CE_I, .DEV_STATUS_I,
    .QUEST_STATUS_I, .OPER_STATUS_I, .STD_EVENT_I, .ERRQ_NOT_EMPTY_I, .ERRQ_NEW_ENTRY_I,
    .OUTPUT_MESSAGE_WAITING_I, .CMD_VALID_I, .CMD_WRITE_I, .CMD_GROUP_I, .CMD_PART_I,
    .CMD_WDATA_I, .SERIAL_POLL_I, .RSP_VALID_O, .RSP_DATA_O, .TOP_STATUS_BYTE_O,
    .SERVICE_REQUEST_O);
  ssr_ctrl_model ssr_ctrl_model_inst (.clk_i(CORE_CLK_I), .en_i(en), .lag_i(lag),
    .srq_i(SERVICE_REQUEST_O), .poll_o(SERIAL_POLL_I), .polls_o(polls));
  initial begin
    CORE_CLK_I = 1'b0;
    forever #25 CORE_CLK_I = ~CORE_CLK_I;
  end
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #1;
  endtask
  // strobe drops one edge before the next command may raise it
  task cmd(input logic w, input logic [2:0] g, input logic [2:0] p, input logic [15:0] d);
    {CMD_VALID_I, CMD_WRITE_I, CMD_GROUP_I, CMD_PART_I, CMD_WDATA_I} = {1'b1, w, g, p, d};
    wt(1);
    CMD_VALID_I = 1'b0;
    rsp = RSP_DATA_O;
    vld = RSP_VALID_O;
    wt(1);
  endtask
  task rd(input logic [2:0] g, input logic [2:0] p, input logic [15:0] e);
    cmd(1'b0, g, p, 16'h0000);
    chk("answer valid", 16'h0001, {15'h0000, vld});
    chk("answer data", e, rsp);
  endtask
  task cb(input logic [7:0] e);
    chk("status byte", {8'h00, e}, {8'h00, TOP_STATUS_BYTE_O});
  endtask
  task srq(input logic e);
    chk("service request", {15'h0000, e}, {15'h0000, SERVICE_REQUEST_O});
  endtask
  task set_st(input int g, input logic [15:0] v);
    case (g)
      0: DEV_STATUS_I = v;
      1: QUEST_STATUS_I = v;
      default: OPER_STATUS_I = v;
    endcase
  endtask
  task wpoll(input logic [7:0] n);
    for (int i = 0; i < 20 && polls !== n; i++) wt(1);
    chk("poll count", {8'h00, n}, {8'h00, polls});
    if (polls !== n) give_verdict;
  endtask
  initial begin
    {DEV_STATUS_I, QUEST_STATUS_I, OPER_STATUS_I, CMD_WDATA_I, STD_EVENT_I} = '0;
    {ERRQ_NOT_EMPTY_I, ERRQ_NEW_ENTRY_I, OUTPUT_MESSAGE_WAITING_I, en, lag} = '0;
    {CMD_VALID_I, CMD_WRITE_I, CMD_GROUP_I, CMD_PART_I} = '0;
    NRST_I = 1'b0;
    CE_I = 1'b1;
    wt(4);
    NRST_I = 1'b1;
    rd(3'h1, 3'h1, 16'h7FFF);
    rd(3'h2, 3'h2, 16'h0000);
    rd(3'h0, 3'h4, 16'h0000);
    rd(3'h4, 3'h4, 16'h0000);
    rd(3'h7, 3'h0, 16'h0000);
    cmd(1'b1, 3'h4, 3'h4, 16'h00FF);
    rd(3'h4, 3'h4, 16'h00FF);
    for (int g = 0; g < 3; g++) begin
      sb = (g == 0) ? 8'h02 : (g == 1) ? 8'h08 : 8'h80;
      cmd(1'b1, g[2:0], 3'h4, 16'hFFFF);
      rd(g[2:0], 3'h4, 16'h7FFF);
      rd(g[2:0], 3'h4, 16'h7FFF);
      cmd(1'b1, g[2:0], 3'h0, 16'h1234);
      set_st(g, 16'h8004);
      wt(3);
      cb(8'h40 | sb);
      srq(1'b1);
      rd(g[2:0], 3'h0, 16'h0004);
      rd(g[2:0], 3'h3, 16'h0004);
      rd(g[2:0], 3'h3, 16'h0000);
      set_st(g, 16'h0000);
      wt(3);
      cb(8'h00);
      srq(1'b0);
    end
    cmd(1'b1, 3'h1, 3'h1, 16'h0001);
    cmd(1'b1, 3'h1, 3'h2, 16'hFFFF);
    rd(3'h1, 3'h2, 16'h7FFF);
    QUEST_STATUS_I = 16'h0003;
    wt(3);
    rd(3'h1, 3'h3, 16'h0001);
    QUEST_STATUS_I = 16'h0000;
    wt(3);
    rd(3'h1, 3'h3, 16'h0003);
    cmd(1'b1, 3'h1, 3'h2, 16'h0000);
    QUEST_STATUS_I = 16'h0001;
    rd(3'h1, 3'h3, 16'h0000);
    rd(3'h1, 3'h3, 16'h0001);
    {en, lag, ERRQ_NOT_EMPTY_I, ERRQ_NEW_ENTRY_I} = {1'b1, 4'h2, 1'b1, 1'b1};
    wt(1);
    ERRQ_NEW_ENTRY_I = 1'b0;
    wpoll(8'h01);
    wt(3);
    chk("poll answer", 16'h0044, RSP_DATA_O);
    srq(1'b0);
    ERRQ_NEW_ENTRY_I = 1'b1;
    wt(1);
    ERRQ_NEW_ENTRY_I = 1'b0;
    wpoll(8'h02);
    OUTPUT_MESSAGE_WAITING_I = 1'b1;
    wt(3);
    cb(8'h54);
    rd(3'h4, 3'h0, 16'h0054);
    {ERRQ_NOT_EMPTY_I, OUTPUT_MESSAGE_WAITING_I} = 2'b00;
    wt(3);
    cb(8'h00);
    // a latched flag with its mask bit clear must stay out of the sum
    cmd(1'b1, 3'h2, 3'h4, 16'h0000);
    OPER_STATUS_I = 16'h0001;
    wt(3);
    cb(8'h00);
    rd(3'h2, 3'h3, 16'h0001);
    OPER_STATUS_I = 16'h0000;
    cmd(1'b1, 3'h3, 3'h4, 16'h0001);
    rd(3'h3, 3'h4, 16'h0001);
    STD_EVENT_I = 8'h03;
    wt(1);
    STD_EVENT_I = 8'h00;
    wt(3);
    cb(8'h60);
    rd(3'h3, 3'h3, 16'h0003);
    wt(3);
    cb(8'h00);
    give_verdict;
  end
endmodule // tb_top
